/* File: ivt_core.sv */
// integer unit sequencer: variant cycle costs, reset traps, memory address shaping
`timescale 1ns/1ps
`include "ivt_map.svh"
module ivt_core #(
   parameter ivt_pkg::ivt_variant_t VARIANT  = ivt_pkg::IVT_VAR_A,
   parameter logic [7:0]            DTM_CODE = 8'h3c,
   parameter logic [7:0]            FTM_CODE = 8'h3d,
   parameter logic [7:0]            WMT_CODE = 8'h3e
) (
   input  wire logic                     clk,
   input  wire logic                     srst,
   input  wire logic                     ce,
   input  wire logic                     ext_reset,
   input  wire logic                     error_mode,
   input  wire logic                     instr_valid,
   input  wire ivt_pkg::ivt_op_t         instr_op,
   input  wire logic                     instr_taken,
   input  wire logic                     instr_reg_reg,
   input  wire logic [4:0]               instr_rd,
   input  wire logic [`IVT_ADDR_W-1:0]   eff_addr,
   input  wire logic [`IVT_TAG_W-1:0]    address_space_tag,
   input  wire logic [`IVT_ADDR_W-1:0]   fetch_addr,
   input  wire logic                     data_translation_miss_req,
   input  wire logic                     fetch_translation_miss_req,
   input  wire logic                     watch_match_req,
   output logic                          instr_ready,
   output logic                          instr_done,
   output logic                          trap_valid,
   output logic [7:0]                    trap_type_code,
   output logic                          mem_req,
   output logic [`IVT_ADDR_W-1:0]        mem_addr,
   output logic [`IVT_TAG_W-1:0]         mem_tag,
   output logic [`IVT_ADDR_W-1:0]        mem_fetch_addr,
   output logic                          msr_read,
   output logic                          msr_write,
   output logic [4:0]                    dest_index,
   output logic [2:0]                    window_ptr,
   output logic [3:0]                    window_count,
   output logic                          halted
);

   ////////////////////////////////////////////////////////////////////////////
   // variant-derived constants

   localparam logic IS_C = (VARIANT == ivt_pkg::IVT_VAR_C);
   localparam logic IS_E = (VARIANT == ivt_pkg::IVT_VAR_E);

   localparam logic [`IVT_ADDR_W-1:0] ADDR_MASK =
      IS_C ? ((32'h1 << `IVT_C_ADDR_BITS) - 32'h1) : 32'hffff_ffff;
   localparam logic [`IVT_TAG_W-1:0] TAG_MASK =
      IS_C ? ((8'h1 << `IVT_C_TAG_BITS) - 8'h1) :
      (IS_E ? ((8'h1 << `IVT_E_TAG_BITS) - 8'h1) : 8'hff);

   localparam logic [3:0] NWIN =
      (VARIANT == ivt_pkg::IVT_VAR_A || VARIANT == ivt_pkg::IVT_VAR_D) ?
      `IVT_NWIN_SHORT : `IVT_NWIN_LONG;
   localparam logic [2:0] WIN_TOP = 3'(NWIN - 4'h1);

   localparam logic [7:0] ERR_CODE = IS_E ? `IVT_TT_ERR_E : `IVT_TT_RESET;

   if (VARIANT > ivt_pkg::IVT_VAR_E) begin : g_bad_variant
      $error("ivt_core: unknown variant");
   end
   if (DTM_CODE == `IVT_TT_RESET || FTM_CODE == `IVT_TT_RESET || WMT_CODE == `IVT_TT_RESET ||
       DTM_CODE == ERR_CODE || FTM_CODE == ERR_CODE || WMT_CODE == ERR_CODE) begin : g_bad_codes
      $error("ivt_core: trap codes collide with reset codes");
   end

   ////////////////////////////////////////////////////////////////////////////
   // cost lookup

   ivt_dec_if u_dec ();

   assign u_dec.op      = instr_op;
   assign u_dec.taken   = instr_taken;
   assign u_dec.reg_reg = instr_reg_reg;

   ivt_cost_table #(
      .VARIANT (VARIANT)
   ) u_cost (
      .lk      (u_dec)
   );

   ////////////////////////////////////////////////////////////////////////////
   // sequencer state

   ivt_pkg::ivt_state_t s_ff;
   ivt_pkg::ivt_state_t nxt_s;

   logic err_edge;
   logic mmu_event;
   logic accept;

   assign err_edge  = error_mode && !s_ff.err_seen && (s_ff.fsm != ivt_pkg::IVT_ST_HALT);
   // the other variants have no translation or watch hardware at all
   assign mmu_event = IS_E && (data_translation_miss_req || fetch_translation_miss_req ||
                               watch_match_req);
   // ready holds off in the cycle that would lose the instruction to a trap
   assign instr_ready = (s_ff.fsm == ivt_pkg::IVT_ST_IDLE) && !ext_reset && !err_edge;
   assign accept      = ce && instr_valid && instr_ready;

   always_comb begin
      nxt_s = s_ff;
      if (ce) begin
         nxt_s.done     = 1'b0;
         nxt_s.trap_vld = 1'b0;
         nxt_s.mem_req  = 1'b0;
         nxt_s.msr_rd   = 1'b0;
         nxt_s.msr_wr   = 1'b0;
         nxt_s.rst_seen = ext_reset;
         nxt_s.err_seen = error_mode;
         if (ext_reset) begin
            nxt_s.fsm = ivt_pkg::IVT_ST_IDLE;
            nxt_s.cnt = '0;
            nxt_s.cwp = 3'h0;
            if (!s_ff.rst_seen) begin
               nxt_s.trap_vld  = 1'b1;
               nxt_s.trap_code = `IVT_TT_RESET;
            end
         end else if (err_edge) begin
            nxt_s.fsm       = ivt_pkg::IVT_ST_HALT;
            nxt_s.cnt       = '0;
            nxt_s.trap_vld  = 1'b1;
            nxt_s.trap_code = ERR_CODE;
         end else begin
            if (mmu_event && s_ff.fsm != ivt_pkg::IVT_ST_HALT) begin
               nxt_s.trap_vld = 1'b1;
               if (data_translation_miss_req) nxt_s.trap_code = DTM_CODE;
               else if (fetch_translation_miss_req) nxt_s.trap_code = FTM_CODE;
               else nxt_s.trap_code = WMT_CODE;
            end
            case (s_ff.fsm)
               ivt_pkg::IVT_ST_IDLE: begin
                  if (instr_valid) begin
                     nxt_s.fetch_addr = fetch_addr & ADDR_MASK;
                     if (u_dec.is_mem) begin
                        nxt_s.mem_req  = 1'b1;
                        nxt_s.mem_addr = eff_addr & ADDR_MASK;
                        nxt_s.mem_tag  = address_space_tag & TAG_MASK;
                     end
                     nxt_s.msr_rd = u_dec.msr_rd;
                     nxt_s.msr_wr = u_dec.msr_wr;
                     if (u_dec.msr_rd) begin
                        nxt_s.dest_idx = (instr_op == ivt_pkg::IVT_OP_STORE_ORDERING_BARRIER) ?
                                         5'h0 : instr_rd;
                     end
                     if (instr_op == ivt_pkg::IVT_OP_SAVE) begin
                        nxt_s.cwp = (s_ff.cwp == 3'h0) ? WIN_TOP : s_ff.cwp - 3'h1;
                     end else if (instr_op == ivt_pkg::IVT_OP_RESTORE) begin
                        nxt_s.cwp = (s_ff.cwp == WIN_TOP) ? 3'h0 : s_ff.cwp + 3'h1;
                     end
                     // costs assume a zero-wait memory; no stall input exists
                     if (u_dec.cost == `IVT_CYC_1) begin
                        nxt_s.done = 1'b1;
                     end else begin
                        nxt_s.fsm = ivt_pkg::IVT_ST_BUSY;
                        nxt_s.cnt = u_dec.cost - `IVT_CYC_1;
                     end
                  end
               end
               ivt_pkg::IVT_ST_BUSY: begin
                  if (s_ff.cnt == `IVT_CYC_1) begin
                     nxt_s.fsm  = ivt_pkg::IVT_ST_IDLE;
                     nxt_s.cnt  = '0;
                     nxt_s.done = 1'b1;
                  end else begin
                     nxt_s.cnt = s_ff.cnt - `IVT_CYC_1;
                  end
               end
               ivt_pkg::IVT_ST_HALT: begin
                  nxt_s.cnt = '0;
               end
               default: begin
                  nxt_s.fsm = ivt_pkg::IVT_ST_IDLE;
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign instr_done     = s_ff.done;
   assign trap_valid     = s_ff.trap_vld;
   assign trap_type_code = s_ff.trap_code;
   assign mem_req        = s_ff.mem_req;
   assign mem_addr       = s_ff.mem_addr;
   assign mem_tag        = s_ff.mem_tag;
   assign mem_fetch_addr = s_ff.fetch_addr;
   assign msr_read       = s_ff.msr_rd;
   assign msr_write      = s_ff.msr_wr;
   assign dest_index     = s_ff.dest_idx;
   assign window_ptr     = s_ff.cwp;
   assign window_count   = NWIN;
   assign halted         = (s_ff.fsm == ivt_pkg::IVT_ST_HALT);

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   sequence s_run;
      ce && !ext_reset && !error_mode;
   endsequence

   sequence s_take5;
      accept && !ext_reset && (u_dec.cost == `IVT_CYC_5);
   endsequence

   sequence s_take2;
      accept && !ext_reset && (u_dec.cost == `IVT_CYC_2);
   endsequence

   chk_error_code: assert property (
      (ce && err_edge && !ext_reset) |=> (trap_valid && trap_type_code == ERR_CODE && halted))
      else $error("error state trap code wrong");

   chk_zero_code_src: assert property (
      (IS_E && $past(ce) && trap_valid && trap_type_code == `IVT_TT_RESET) |-> $past(ext_reset))
      else $error("zero trap code without external reset");

   chk_no_mmu_trap: assert property (
      (!IS_E && trap_valid) |->
         !(trap_type_code == DTM_CODE || trap_type_code == FTM_CODE || trap_type_code == WMT_CODE))
      else $error("translation or watch trap in wrong variant");

   chk_barrier_read: assert property (
      (accept && !ext_reset && instr_op == ivt_pkg::IVT_OP_STORE_ORDERING_BARRIER) |=>
         (msr_read && !msr_write && dest_index == 5'h0))
      else $error("barrier not executed as read with destination zero");

   chk_aux_write: assert property (
      (accept && !ext_reset && instr_op == ivt_pkg::IVT_OP_WRITE_AUXILIARY_STATE_REG) |=>
         (msr_write && !msr_read))
      else $error("auxiliary write not taken as multiply-step write");

   chk_addr_shape: assert property (
      (accept && !ext_reset && u_dec.is_mem) |=>
         (mem_req && mem_addr == ($past(eff_addr) & ADDR_MASK) &&
          mem_tag == ($past(address_space_tag) & TAG_MASK)))
      else $error("memory address or tag not presented");

   chk_addr_width: assert property (
      mem_req |-> ((!IS_C || (mem_addr[31:24] == 8'h0 && mem_tag[7:3] == 5'h0)) &&
                   (!IS_E || mem_tag[7] == 1'b0) &&
                   (IS_C || IS_E || mem_tag == $past(address_space_tag))))
      else $error("address or tag width wrong for variant");

   chk_window_wrap: assert property (
      (accept && !ext_reset && instr_op == ivt_pkg::IVT_OP_SAVE && window_ptr == 3'h0) |=>
         (window_ptr == WIN_TOP))
      else $error("window pointer wrap wrong");

   chk_single_cycle: assert property (
      (accept && !ext_reset && u_dec.cost == `IVT_CYC_1) |=>
         (instr_done && !halted && s_ff.fsm == ivt_pkg::IVT_ST_IDLE))
      else $error("one-cycle instruction not finished");

   chk_two_span: assert property (
      s_take2 ##1 s_run |-> (!instr_done ##1 instr_done))
      else $error("two-cycle instruction length wrong");

   chk_branch_cost: assert property (
      (instr_valid && instr_op == ivt_pkg::IVT_OP_BRANCH && !instr_taken) |->
         (u_dec.cost == ((VARIANT == ivt_pkg::IVT_VAR_A) ? `IVT_CYC_2 : `IVT_CYC_1)))
      else $error("untaken branch cost wrong");

   chk_trap_cost_d: assert property (
      (VARIANT == ivt_pkg::IVT_VAR_D && instr_op == ivt_pkg::IVT_OP_TRAP_COND && instr_taken) |->
         u_dec.cost == `IVT_CYC_5)
      else $error("taken conditional trap cost wrong");

   chk_wide_load: assert property (
      ((VARIANT == ivt_pkg::IVT_VAR_D || IS_E) && instr_op == ivt_pkg::IVT_OP_LOAD) |->
         u_dec.cost == `IVT_CYC_1)
      else $error("wide-bus load not one cycle");

   chk_mul_cost: assert property (
      (IS_E && instr_op == ivt_pkg::IVT_OP_MULTIPLY) |-> u_dec.cost == `IVT_CYC_5)
      else $error("multiply cost wrong");

   chk_long_early: assert property (
      s_take5 ##1 s_run[*3] |=> !instr_done)
      else $error("five-cycle instruction finished early");

   chk_long_span: assert property (
      s_take5 ##1 s_run[*4] |=> instr_done)
      else $error("five-cycle instruction finished late");

   chk_reset_code: assert property (
      ($past(ce) && ce && ext_reset && !$past(ext_reset)) |=>
         (trap_valid && trap_type_code == `IVT_TT_RESET && !halted && window_ptr == 3'h0))
      else $error("external reset trap wrong");

   chk_halt_hold: assert property (
      (halted && !ext_reset) |=> (halted && !instr_ready))
      else $error("halt left without external reset");

   chk_full_addr: assert property (
      (accept && !IS_C && u_dec.is_mem) |=> (mem_addr == $past(eff_addr)))
      else $error("full data address not presented");

   chk_fetch_shape: assert property (
      accept |=> (IS_C ? (mem_fetch_addr == {8'h00, $past(fetch_addr[23:0])}) :
                         (mem_fetch_addr == $past(fetch_addr))))
      else $error("fetch address not presented");

   chk_dstore_cost_a: assert property (
      (VARIANT == ivt_pkg::IVT_VAR_A && instr_op == ivt_pkg::IVT_OP_STORE_DOUBLE) |->
         u_dec.cost == `IVT_CYC_4)
      else $error("double store cost wrong");

   chk_wide_store: assert property (
      (IS_E && !instr_reg_reg &&
       (instr_op == ivt_pkg::IVT_OP_STORE || instr_op == ivt_pkg::IVT_OP_STORE_DOUBLE)) |->
         u_dec.cost == `IVT_CYC_1)
      else $error("wide-bus store not one cycle");

endmodule // ivt_core

/* File: ivt_map.svh */
// address, tag, window, trap code and cycle-cost constants of the variant timing block
`ifndef IVT_MAP_SVH
`define IVT_MAP_SVH

`define IVT_ADDR_W      32
`define IVT_TAG_W       8
`define IVT_C_ADDR_BITS 24
`define IVT_C_TAG_BITS  3
`define IVT_E_TAG_BITS  7

`define IVT_NWIN_SHORT  4'h7
`define IVT_NWIN_LONG   4'h8

`define IVT_TT_RESET    8'h00
`define IVT_TT_ERR_E    8'h20

`define IVT_CNT_W       3
`define IVT_CYC_1       3'h1
`define IVT_CYC_2       3'h2
`define IVT_CYC_3       3'h3
`define IVT_CYC_4       3'h4
`define IVT_CYC_5       3'h5

`endif

/* File: ivt_pkg.sv */
// types shared by the variant timing block
`include "ivt_map.svh"
package ivt_pkg;

   typedef enum logic [2:0] {
      IVT_VAR_A = 3'h0,
      IVT_VAR_B = 3'h1,
      IVT_VAR_C = 3'h2,
      IVT_VAR_D = 3'h3,
      IVT_VAR_E = 3'h4
   } ivt_variant_t;

   typedef enum logic [4:0] {
      IVT_OP_OTHER,
      IVT_OP_LOAD,
      IVT_OP_LOAD_DOUBLE,
      IVT_OP_STORE,
      IVT_OP_STORE_DOUBLE,
      IVT_OP_ATOMIC_BYTE_LOAD_STORE,
      IVT_OP_SWAP,
      IVT_OP_BRANCH,
      IVT_OP_TRAP_COND,
      IVT_OP_JUMP_AND_LINK,
      IVT_OP_RETURN_FROM_TRAP,
      IVT_OP_FP_QUEUE_ENTRY_STORE,
      IVT_OP_MULTIPLY,
      IVT_OP_STORE_ORDERING_BARRIER,
      IVT_OP_WRITE_AUXILIARY_STATE_REG,
      IVT_OP_WRITE_MULTIPLY_STEP_REG,
      IVT_OP_READ_MULTIPLY_STEP_REG,
      IVT_OP_SAVE,
      IVT_OP_RESTORE
   } ivt_op_t;

   // gray along idle -> busy -> halt
   typedef enum logic [1:0] {
      IVT_ST_IDLE = 2'h0,
      IVT_ST_BUSY = 2'h1,
      IVT_ST_HALT = 2'h3
   } ivt_fsm_t;

   typedef struct packed {
      ivt_fsm_t                fsm;
      logic [`IVT_CNT_W-1:0]   cnt;
      logic                    done;
      logic                    trap_vld;
      logic [7:0]              trap_code;
      logic                    err_seen;
      logic                    rst_seen;
      logic                    mem_req;
      logic [`IVT_ADDR_W-1:0]  mem_addr;
      logic [`IVT_TAG_W-1:0]   mem_tag;
      logic [`IVT_ADDR_W-1:0]  fetch_addr;
      logic                    msr_rd;
      logic                    msr_wr;
      logic [4:0]              dest_idx;
      logic [2:0]              cwp;
   } ivt_state_t;

endpackage

/* File: ivt_dec_if.sv */
// decode request and cost answer between the sequencer and the cost table
`timescale 1ns/1ps
`include "ivt_map.svh"
interface ivt_dec_if;
   ivt_pkg::ivt_op_t        op;
   logic                    taken;
   logic                    reg_reg;
   logic [`IVT_CNT_W-1:0]   cost;
   logic                    msr_rd;
   logic                    msr_wr;
   logic                    is_mem;

   modport issue  (output op, taken, reg_reg, input  cost, msr_rd, msr_wr, is_mem);
   modport lookup (input  op, taken, reg_reg, output cost, msr_rd, msr_wr, is_mem);
endinterface // ivt_dec_if

/* File: ivt_cost_table.sv */
// per-variant cycle cost and register decode of one integer instruction
`timescale 1ns/1ps
`include "ivt_map.svh"
module ivt_cost_table #(
   parameter ivt_pkg::ivt_variant_t VARIANT = ivt_pkg::IVT_VAR_A
) (
   ivt_dec_if.lookup lk
);
   localparam logic IS_A  = (VARIANT == ivt_pkg::IVT_VAR_A);
   localparam logic IS_D  = (VARIANT == ivt_pkg::IVT_VAR_D);
   localparam logic IS_E  = (VARIANT == ivt_pkg::IVT_VAR_E);
   // wide-bus variants take a load and an untaken conditional trap in one cycle
   localparam logic WIDE  = IS_D || IS_E;

   always_comb begin
      lk.cost   = `IVT_CYC_1;
      lk.msr_rd = 1'b0;
      lk.msr_wr = 1'b0;
      lk.is_mem = 1'b0;
      case (lk.op)
         ivt_pkg::IVT_OP_LOAD: begin
            lk.is_mem = 1'b1;
            lk.cost   = WIDE ? `IVT_CYC_1 : `IVT_CYC_2;
         end
         ivt_pkg::IVT_OP_LOAD_DOUBLE: begin
            lk.is_mem = 1'b1;
            lk.cost   = IS_E ? `IVT_CYC_1 : (IS_D ? `IVT_CYC_2 : `IVT_CYC_3);
         end
         ivt_pkg::IVT_OP_STORE: begin
            lk.is_mem = 1'b1;
            if (IS_E) lk.cost = lk.reg_reg ? `IVT_CYC_2 : `IVT_CYC_1;
            else lk.cost = IS_D ? `IVT_CYC_2 : `IVT_CYC_3;
         end
         ivt_pkg::IVT_OP_STORE_DOUBLE: begin
            lk.is_mem = 1'b1;
            if (IS_E) lk.cost = lk.reg_reg ? `IVT_CYC_2 : `IVT_CYC_1;
            else lk.cost = IS_D ? `IVT_CYC_3 : `IVT_CYC_4;
         end
         ivt_pkg::IVT_OP_ATOMIC_BYTE_LOAD_STORE, ivt_pkg::IVT_OP_SWAP: begin
            lk.is_mem = 1'b1;
            if (IS_E) lk.cost = lk.reg_reg ? `IVT_CYC_2 : `IVT_CYC_1;
            else lk.cost = IS_D ? `IVT_CYC_1 : `IVT_CYC_4;
         end
         ivt_pkg::IVT_OP_BRANCH:
            lk.cost = (IS_A && !lk.taken) ? `IVT_CYC_2 : `IVT_CYC_1;
         ivt_pkg::IVT_OP_TRAP_COND:
            if (lk.taken) lk.cost = IS_D ? `IVT_CYC_5 : `IVT_CYC_2;
            else lk.cost = WIDE ? `IVT_CYC_1 : `IVT_CYC_3;
         ivt_pkg::IVT_OP_JUMP_AND_LINK:
            lk.cost = IS_E ? `IVT_CYC_1 : `IVT_CYC_2;
         ivt_pkg::IVT_OP_RETURN_FROM_TRAP:
            lk.cost = `IVT_CYC_2;
         ivt_pkg::IVT_OP_FP_QUEUE_ENTRY_STORE: begin
            // outside the wide variant this is costed as a double store
            lk.is_mem = 1'b1;
            lk.cost   = IS_E ? `IVT_CYC_2 : (IS_D ? `IVT_CYC_3 : `IVT_CYC_4);
         end
         ivt_pkg::IVT_OP_MULTIPLY:
            lk.cost = IS_E ? `IVT_CYC_5 : `IVT_CYC_1;
         ivt_pkg::IVT_OP_STORE_ORDERING_BARRIER, ivt_pkg::IVT_OP_READ_MULTIPLY_STEP_REG:
            lk.msr_rd = 1'b1;
         ivt_pkg::IVT_OP_WRITE_AUXILIARY_STATE_REG, ivt_pkg::IVT_OP_WRITE_MULTIPLY_STEP_REG:
            lk.msr_wr = 1'b1;
         default:
            lk.cost = `IVT_CYC_1;
      endcase
   end
endmodule // ivt_cost_table

/* File: ivt_mem_model.sv */
// zero-wait memory model that records every access of the block
`timescale 1ns/1ps
module ivt_mem_model (
   input  wire logic        clk,
   input  wire logic        mem_req,
   input  wire logic [31:0] mem_addr,
   input  wire logic [7:0]  mem_tag,
   input  wire logic [31:0] mem_fetch_addr,
   output logic      [31:0] last_addr,
   output logic      [7:0]  last_tag,
   output logic      [31:0] last_fetch
);
   // answers within the request cycle, so no wait ever stretches a cost
   always_ff @(posedge clk) begin
      last_fetch <= mem_fetch_addr;
      if (mem_req) begin
         last_addr <= mem_addr;
         last_tag  <= mem_tag;
      end
   end
endmodule // ivt_mem_model

/* File: tb_integer_unit_variant_timing.sv */
// bench: variants A, C, E and D side by side on one shared stimulus
`timescale 1ns/1ps
module tb_integer_unit_variant_timing;
   localparam ivt_pkg::ivt_variant_t VS [4] = '{ivt_pkg::IVT_VAR_A, ivt_pkg::IVT_VAR_C, ivt_pkg::IVT_VAR_E,
                                                ivt_pkg::IVT_VAR_D};
   logic clk = 1'b0, srst = 1'b1, ext_reset = 1'b0, error_mode = 1'b0;
   logic vld = 1'b0, tkn = 1'b0, rr = 1'b0, dtm = 1'b0, ftm = 1'b0, wmt = 1'b0;
   ivt_pkg::ivt_op_t op = ivt_pkg::IVT_OP_OTHER;
   logic [4:0]  rd = 5'h00;
   logic [31:0] ea = 32'h0, fa = 32'h0;
   logic [7:0]  tag = 8'h00;
   logic        rdy [4], done [4], tv [4], mreq [4], mrd [4], mwr [4], hlt [4];
   logic        seen_rd [4], seen_wr [4], seen_tv [4];
   logic [7:0]  ttc [4], mtag [4], ltag [4];
   logic [31:0] maddr [4], mfa [4], laddr [4], lfetch [4];
   logic [4:0]  didx [4];
   logic [2:0]  wp [4];
   logic [3:0]  wc [4], got [4];
   int          errors = 0, samples_checked = 0;

   initial forever #2.5 clk = ~clk;

   for (genvar g = 0; g < 4; g++) begin : g_var
      ivt_core #(.VARIANT(VS[g])) i_ivt_core (.clk(clk), .srst(srst), .ce(1'b1), .ext_reset(ext_reset),
         .error_mode(error_mode), .instr_valid(vld), .instr_op(op), .instr_taken(tkn), .instr_reg_reg(rr),
         .instr_rd(rd), .eff_addr(ea), .address_space_tag(tag), .fetch_addr(fa),
         .data_translation_miss_req(dtm), .fetch_translation_miss_req(ftm), .watch_match_req(wmt),
         .instr_ready(rdy[g]), .instr_done(done[g]), .trap_valid(tv[g]), .trap_type_code(ttc[g]),
         .mem_req(mreq[g]), .mem_addr(maddr[g]), .mem_tag(mtag[g]), .mem_fetch_addr(mfa[g]),
         .msr_read(mrd[g]), .msr_write(mwr[g]), .dest_index(didx[g]), .window_ptr(wp[g]),
         .window_count(wc[g]), .halted(hlt[g]));
      ivt_mem_model i_ivt_mem_model (.clk(clk), .mem_req(mreq[g]), .mem_addr(maddr[g]), .mem_tag(mtag[g]),
         .mem_fetch_addr(mfa[g]), .last_addr(laddr[g]), .last_tag(ltag[g]), .last_fetch(lfetch[g]));
   end

   ////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // one instruction to every variant; got holds the cycles to done
   task automatic run(input logic [4:0] o, input logic t, input logic r, input logic [4:0] d);
      @(negedge clk);
      op = ivt_pkg::ivt_op_t'(o);
      tkn = t;
      rr = r;
      rd = d;
      vld = 1'b1;
      for (int i = 0; i < 4; i++) begin
         check(rdy[i], 1'b1, "ready");
         got[i] = 4'h0;
         seen_rd[i] = 1'b0;
         seen_wr[i] = 1'b0;
      end
      // k = 0 is the take edge, so done seen after edge k means a cost of k+1
      for (int k = 0; k < 9; k++) begin
         @(posedge clk);
         #1;
         for (int i = 0; i < 4; i++) begin
            if (done[i] === 1'b1 && got[i] == 4'h0) got[i] = 4'(k + 1);
            seen_rd[i] |= (mrd[i] === 1'b1);
            seen_wr[i] |= (mwr[i] === 1'b1);
         end
         @(negedge clk);
         vld = 1'b0;
      end
      for (int i = 0; i < 4; i++) begin
         if (got[i] == 4'h0) begin
            check(done[i], 1'b1, "no completion");
            give_verdict();
         end
      end
   endtask

   task automatic t_costs();
      // op, taken, reg+reg, then cost for A, C, E, D
      logic [31:0] tbl [15] = '{32'h00001111, 32'h01002211, 32'h02003312, 32'h03003312, 32'h03013322,
         32'h04004413, 32'h05004411, 32'h06004411, 32'h07002111, 32'h08102225, 32'h08003311, 32'h09002212,
         32'h0a002222, 32'h0b004423, 32'h0c001151};
      for (int n = 0; n < 15; n++) begin
         run(tbl[n][28:24], tbl[n][20], tbl[n][16], 5'h00);
         for (int i = 0; i < 4; i++) begin
            check(got[i], tbl[n][15-4*i -: 4], "cost");
         end
      end
      $display("costs test done");
   endtask

   task automatic t_addr();
      @(negedge clk);
      ea = 32'hfedcba98;
      tag = 8'hff;
      fa = 32'h89abcdef;
      run(5'h01, 1'b0, 1'b0, 5'h00);
      check(laddr[0], 32'hfedcba98, "addr A");
      check(ltag[0], 8'hff, "tag A");
      check(lfetch[0], 32'h89abcdef, "fetch A");
      check(laddr[1], 32'h00dcba98, "addr C");
      check(ltag[1], 8'h07, "tag C");
      check(lfetch[1], 32'h00abcdef, "fetch C");
      check(laddr[2], 32'hfedcba98, "addr E");
      check(ltag[2], 8'h7f, "tag E");
      check(lfetch[2], 32'h89abcdef, "fetch E");
      check(laddr[3], 32'hfedcba98, "addr D");
      check(ltag[3], 8'hff, "tag D");
      check(lfetch[3], 32'h89abcdef, "fetch D");
      $display("address test done");
   endtask

   task automatic t_regs();
      run(5'h10, 1'b0, 1'b0, 5'h05);
      check(didx[2], 5'h05, "read index");
      run(5'h0d, 1'b0, 1'b0, 5'h07);
      for (int i = 0; i < 4; i++) check({seen_rd[i], didx[i]}, 6'h20, "barrier");
      run(5'h0e, 1'b0, 1'b0, 5'h09);
      for (int i = 0; i < 4; i++) check({seen_wr[i], didx[i]}, 6'h20, "aux write");
      run(5'h11, 1'b0, 1'b0, 5'h00);
      for (int i = 0; i < 4; i++) begin
         check({wc[i], 1'b0, wp[i]}, (i == 0 || i == 3) ? 8'h76 : 8'h87, "windows");
      end
      run(5'h12, 1'b0, 1'b0, 5'h00);
      for (int i = 0; i < 4; i++) check(wp[i], 3'h0, "restore");
      $display("register test done");
   endtask

   // sel: 0..2 miss and watch requests, 3 error state, 4 external reset
   task automatic trap_evt(input int sel, input logic [31:0] codes, input logic [3:0] fire);
      @(negedge clk);
      case (sel)
         0: dtm = 1'b1;
         1: ftm = 1'b1;
         2: wmt = 1'b1;
         3: error_mode = 1'b1;
         default: ext_reset = 1'b1;
      endcase
      for (int i = 0; i < 4; i++) seen_tv[i] = 1'b0;
      for (int k = 0; k < 3; k++) begin
         @(posedge clk);
         #1;
         for (int i = 0; i < 4; i++) seen_tv[i] |= (tv[i] === 1'b1);
         @(negedge clk);
         {dtm, ftm, wmt, error_mode, ext_reset} = 5'h00;
      end
      for (int i = 0; i < 4; i++) begin
         check(seen_tv[i], fire[i], "trap seen");
         if (fire[i]) check(ttc[i], codes[31-8*i -: 8], "trap code");
      end
   endtask

   task automatic t_traps();
      trap_evt(0, 32'h00003c00, 4'b0100);
      trap_evt(1, 32'h00003d00, 4'b0100);
      trap_evt(2, 32'h00003e00, 4'b0100);
      trap_evt(3, 32'h00002000, 4'b1111);
      for (int i = 0; i < 4; i++) check({hlt[i], rdy[i]}, 2'h2, "halt");
      trap_evt(4, 32'h00000000, 4'b1111);
      for (int i = 0; i < 4; i++) check(hlt[i], 1'b0, "reset clears halt");
      $display("trap test done");
   endtask

   initial begin
      repeat (12) @(posedge clk);
      @(negedge clk);
      srst = 1'b0;
      t_costs();
      t_addr();
      t_regs();
      t_traps();
      give_verdict();
   end
endmodule // tb_integer_unit_variant_timing
